//--- rtl/field_readout.sv
// measurement sequencing, power states and result formatting for a three-axis field sensor
module field_readout
  import field_readout_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // register access from the serial slave
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_rd,
  input  wire logic        burst_start,
  output logic      [31:0] reg_rdata,
  // converter results
  input  wire logic [11:0] adc_x_inner,
  input  wire logic [11:0] adc_x_diff,
  input  wire logic [11:0] adc_x_sum,
  input  wire logic [11:0] adc_y_inner,
  input  wire logic [11:0] adc_y_diff,
  input  wire logic [11:0] adc_y_sum,
  input  wire logic [11:0] adc_z_inner,
  input  wire logic [11:0] adc_temp,
  // status to analog front end
  output logic             front_end_on,
  output logic             fir_enable,
  output logic             sample_strobe
);
  //////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // microsecond tick divider
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic       tick;
  always_comb begin
    tick    = (div_r == 8'(TICK_CYC - 1));
    div_nxt = tick ? 8'h00 : div_r + 8'h01;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) div_r <= 8'h00;
    else div_r <= div_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration and power registers
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [31:0] pwr_r;
  logic [31:0] pwr_nxt;
  always_comb begin
    cfg_nxt = cfg_r;
    pwr_nxt = pwr_r;
    if (reg_wr && reg_addr == CONFIG_ADDR) cfg_nxt = reg_wdata & CONFIG_WMASK;
    if (reg_wr && reg_addr == POWER_ADDR) pwr_nxt = reg_wdata & POWER_WMASK;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CONFIG_RESET;
      pwr_r <= POWER_RESET;
    end else begin
      cfg_r <= cfg_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  logic [1:0] pstate;
  logic [2:0] inact_sel;
  logic [2:0] bw_sel;
  logic [1:0] scheme;
  logic [2:0] ch_en;
  logic [1:0] ch_cnt;
  assign pstate    = pwr_r[PSTATE_LO +: 2];
  assign inact_sel = pwr_r[INACT_LO +: 3];
  assign bw_sel    = cfg_r[BW_LO +: 3];
  assign scheme    = cfg_r[SCHEME_LO +: 2];
  assign ch_en     = {cfg_r[CH_Z_BIT], cfg_r[CH_Y_BIT], cfg_r[CH_X_BIT]};
  assign ch_cnt    = 2'({1'b0, ch_en[0]} + {1'b0, ch_en[1]} + {1'b0, ch_en[2]});
  // values 0..2 filter on, 4..6 off; undefined codes leave it off
  assign fir_enable = (bw_sel <= 3'h2);

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  typedef enum logic [1:0] {
    SQ_STARTUP  = 2'h0,
    SQ_MEASURE  = 2'h1,
    SQ_INACTIVE = 2'h2,
    SQ_SLEEP    = 2'h3
  } seq_type;

  seq_type     seq_r;
  seq_type     seq_nxt;
  logic [19:0] us_r;
  logic [19:0] us_nxt;
  logic [13:0] temp_us_r;
  logic [13:0] temp_us_nxt;
  logic [3:0]  cyc_r;
  logic [3:0]  cyc_nxt;
  logic        temp_go;
  logic        sample_go;

  always_comb begin
    seq_nxt     = seq_r;
    us_nxt      = us_r;
    temp_us_nxt = temp_us_r;
    cyc_nxt     = cyc_r;
    temp_go     = 1'b0;
    sample_go   = 1'b0;
    if (pstate == PS_SLEEP) begin
      seq_nxt = SQ_SLEEP;
      us_nxt  = 20'h0;
    end else begin
      case (seq_r)
        SQ_SLEEP: begin
          seq_nxt = SQ_STARTUP;
          us_nxt  = 20'h0;
        end
        SQ_STARTUP: begin
          if (tick) begin
            us_nxt = us_r + 20'h1;
            if (us_r == 20'(STARTUP_US - 1)) begin
              seq_nxt     = SQ_MEASURE;
              us_nxt      = 20'h0;
              temp_go     = 1'b1;
              temp_us_nxt = 14'h0;
              cyc_nxt     = 4'h0;
            end
          end
        end
        SQ_MEASURE: begin
          if (tick) begin
            us_nxt = us_r + 20'h1;
            if (pstate == PS_ACTIVE) begin
              temp_us_nxt = temp_us_r + 14'h1;
              if (temp_us_r == 14'(TEMP_US - 1)) begin
                temp_go     = 1'b1;
                temp_us_nxt = 14'h0;
              end
            end
            // >= so a shorter period chosen mid-measurement ends it instead of wrapping the counter
            if (us_r >= update_us(bw_sel, ch_cnt) - 20'h1) begin
              sample_go = 1'b1;
              us_nxt    = 20'h0;
              if (pstate == PS_DUTY) begin
                seq_nxt = SQ_INACTIVE;
                cyc_nxt = (cyc_r == 4'(TEMP_DUTY_CNT - 1)) ? 4'h0 : cyc_r + 4'h1;
                if (cyc_r == 4'(TEMP_DUTY_CNT - 1)) temp_go = 1'b1;
              end
            end
          end
        end
        SQ_INACTIVE: begin
          if (pstate != PS_DUTY) begin
            seq_nxt = SQ_MEASURE;
            us_nxt  = 20'h0;
          end else if (tick) begin
            us_nxt = us_r + 20'h1;
            if (us_r >= inactive_us(inact_sel) - 20'h1) begin
              seq_nxt = SQ_MEASURE;
              us_nxt  = 20'h0;
            end
          end
        end
        default: seq_nxt = SQ_STARTUP;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_r     <= SQ_STARTUP;
      us_r      <= 20'h0;
      temp_us_r <= 14'h0;
      cyc_r     <= 4'h0;
    end else begin
      seq_r     <= seq_nxt;
      us_r      <= us_nxt;
      temp_us_r <= temp_us_nxt;
      cyc_r     <= cyc_nxt;
    end
  end

  assign front_end_on  = (seq_r == SQ_MEASURE);
  assign sample_strobe = sample_go;

  //////////////////////////////////////////////////////////////////////////////
  // live results
  logic [11:0] x_r, x_nxt, y_r, y_nxt, z_r, z_nxt, t_r, t_nxt;
  logic [1:0]  org_r, org_nxt;
  logic [1:0]  org_sel;
  always_comb begin
    // alternating starts on difference, or on sum if the stored origin is difference, then flips
    case (scheme)
      SC_INNER: org_sel = 2'h0;
      SC_DIFF:  org_sel = 2'h1;
      SC_SUM:   org_sel = 2'h2;
      // flipping on the stored origin keeps the first alternating sample unlike the last one
      default:  org_sel = (org_r == 2'h1) ? 2'h2 : 2'h1;
    endcase
    x_nxt   = x_r;
    y_nxt   = y_r;
    z_nxt   = z_r;
    t_nxt   = t_r;
    org_nxt = org_r;
    if (sample_go) begin
      org_nxt = org_sel;
      if (ch_en[0]) x_nxt = (org_sel == 2'h1) ? adc_x_diff : (org_sel == 2'h2) ? adc_x_sum : adc_x_inner;
      if (ch_en[1]) y_nxt = (org_sel == 2'h1) ? adc_y_diff : (org_sel == 2'h2) ? adc_y_sum : adc_y_inner;
      if (ch_en[2]) z_nxt = adc_z_inner;
    end
    if (temp_go) t_nxt = adc_temp;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      x_r <= 12'h000; y_r <= 12'h000; z_r <= 12'h000; t_r <= 12'h000; org_r <= 2'h0;
    end else begin
      x_r <= x_nxt; y_r <= y_nxt; z_r <= z_nxt; t_r <= t_nxt; org_r <= org_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // snapshot for burst reads
  logic [31:0] upper_live;
  logic [31:0] lower_live;
  logic [31:0] upper_snap;
  logic [31:0] lower_snap;
  assign upper_live = {x_r[11:4], y_r[11:4], z_r[11:4], 2'b00, t_r[11:6]};
  assign lower_live = {11'h000, 1'b0, x_r[3:0], y_r[3:0], z_r[3:0], org_r, t_r[5:0]};

  // snapshot taken once at burst start; both registers read from it
  sample_hold #(.WIDTH(32)) u_hold (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .load      (burst_start),
    .upper_in  (upper_live),
    .lower_in  (lower_live),
    .upper_out (upper_snap),
    .lower_out (lower_snap)
  );

  // registered read data; unmapped reads return zero
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        CONFIG_ADDR:    rdata_nxt = cfg_r;
        POWER_ADDR:     rdata_nxt = pwr_r;
        RES_UPPER_ADDR: rdata_nxt = upper_snap;
        RES_LOWER_ADDR: rdata_nxt = lower_snap;
        default:        rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rdata_r <= 32'h0000_0000;
    else rdata_r <= rdata_nxt;
  end
  assign reg_rdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  // cycles spent in startup; the wake check needs the whole delay, not just a few edges
  logic [19:0] wake_cyc_r;
  logic [19:0] wake_cyc_nxt;
  always_comb wake_cyc_nxt = (seq_r == SQ_STARTUP) ? wake_cyc_r + 20'h1 : 20'h0;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) wake_cyc_r <= 20'h0;
    else wake_cyc_r <= wake_cyc_nxt;
  end

  sequence leave_sleep_s;
    seq_r == SQ_SLEEP ##1 seq_r == SQ_STARTUP;
  endsequence

  chk_sleep_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_r == SQ_SLEEP |=> $stable(x_r) && $stable(t_r))
    else $error("results changed in sleep");
  chk_sleep_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pstate == PS_SLEEP |=> seq_r == SQ_SLEEP)
    else $error("sleep state not entered");
  chk_wake_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    leave_sleep_s |-> seq_r != SQ_MEASURE [*8])
    else $error("measured too soon after sleep");
  chk_wake_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_r == SQ_STARTUP && seq_nxt == SQ_MEASURE |-> wake_cyc_r >= 20'(STARTUP_US * TICK_CYC - TICK_CYC))
    else $error("startup delay cut short");
  chk_fir_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fir_enable == (cfg_r[23:21] <= 3'h2))
    else $error("filter enable mismatch");
  chk_origin_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sample_go && scheme == SC_DIFF |=> org_r == 2'h1)
    else $error("origin code wrong");
  chk_alt_flip: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sample_go && scheme == SC_ALT |=> org_r != $past(org_r) || $past(org_r) == 2'h0)
    else $error("alternating origin did not flip");
  chk_snap_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !burst_start |=> $stable(upper_snap) && $stable(lower_snap))
    else $error("snapshot changed mid burst");
  chk_duty_rest: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sample_go && pstate == PS_DUTY |=> seq_r == SQ_INACTIVE)
    else $error("no inactive phase after sample");
  chk_upper_pack: assert property (@(posedge sys_clk) disable iff (!rst_n)
    upper_live[31:24] == x_r[11:4] && lower_live[19:16] == x_r[3:0])
    else $error("axis packing wrong");
endmodule

//--- rtl/sample_hold.sv
// result word pair held for one burst read
module sample_hold
  import field_readout_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // capture side
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] upper_in,
  input  wire logic [WIDTH-1:0] lower_in,
  // read side
  output logic      [WIDTH-1:0] upper_out,
  output logic      [WIDTH-1:0] lower_out
);
  logic [WIDTH-1:0] upper_r;
  logic [WIDTH-1:0] upper_nxt;
  logic [WIDTH-1:0] lower_r;
  logic [WIDTH-1:0] lower_nxt;

  // refuse a width that leaves no word to hold
  if (WIDTH < 1) begin : g_width_chk
    $error("sample_hold WIDTH must be at least 1");
  end

  // both halves load on the same edge so they never straddle samples
  always_comb begin
    upper_nxt = load ? upper_in : upper_r;
    lower_nxt = load ? lower_in : lower_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_r <= '0;
      lower_r <= '0;
    end else begin
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
    end
  end

  assign upper_out = upper_r;
  assign lower_out = lower_r;
endmodule

//--- shared/field_readout_pkg.sv
// shared constants for the three-axis field readout and power sequencer
package field_readout_pkg;
  // register offsets
  localparam logic [7:0] CONFIG_ADDR    = 8'h02;
  localparam logic [7:0] POWER_ADDR     = 8'h27;
  localparam logic [7:0] RES_UPPER_ADDR = 8'h28;
  localparam logic [7:0] RES_LOWER_ADDR = 8'h29;
  // configuration fields
  localparam int CH_X_BIT      = 6;
  localparam int CH_Y_BIT      = 7;
  localparam int CH_Z_BIT      = 8;
  localparam int SCHEME_LO     = 19;
  localparam int BW_LO         = 21;
  // power control fields
  localparam int PSTATE_LO     = 0;
  localparam int INACT_LO      = 4;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_01c0;
  localparam logic [31:0] POWER_RESET  = 32'h0000_0000;
  localparam logic [31:0] POWER_WMASK  = 32'h0000_007f;
  localparam logic [31:0] CONFIG_WMASK = 32'h00ff_ffff;
  // lower register origin field
  localparam int ORIGIN_LO     = 6;
  // timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int TICK_US       = 1;
  localparam int TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
  localparam int STARTUP_US    = 8000;
  localparam int TEMP_US       = 8000;
  localparam int TEMP_DUTY_CNT = 10;
  localparam int RD_BYTES      = 8;

  typedef enum logic [1:0] {
    PS_ACTIVE = 2'h0,
    PS_SLEEP  = 2'h1,
    PS_DUTY   = 2'h2
  } power_state_type;

  typedef enum logic [1:0] {
    SC_INNER = 2'h0,
    SC_DIFF  = 2'h1,
    SC_SUM   = 2'h2,
    SC_ALT   = 2'h3
  } scheme_type;

  // inactive interval per field value, microseconds
  function automatic logic [19:0] inactive_us(input logic [2:0] v);
    case (v)
      3'h0: inactive_us = 20'd500;
      3'h1: inactive_us = 20'd1000;
      3'h2: inactive_us = 20'd5000;
      3'h3: inactive_us = 20'd10000;
      3'h4: inactive_us = 20'd50000;
      3'h5: inactive_us = 20'd100000;
      3'h6: inactive_us = 20'd500000;
      default: inactive_us = 20'd1000000;
    endcase
  endfunction

  // update period in microseconds, per bandwidth and channel count
  function automatic logic [19:0] update_us(input logic [2:0] bw, input logic [1:0] n);
    logic [19:0] one;
    logic [19:0] two;
    logic [19:0] three;
    one = 20'd160; two = 20'd330; three = 20'd495;
    case (bw)
      3'h1: begin one = 20'd80; two = 20'd170; three = 20'd255; end
      3'h2: begin one = 20'd40; two = 20'd90; three = 20'd135; end
      3'h4: begin one = 20'd64; two = 20'd138; three = 20'd207; end
      3'h5: begin one = 20'd32; two = 20'd74; three = 20'd111; end
      3'h6: begin one = 20'd16; two = 20'd42; three = 20'd63; end
      default: begin one = 20'd160; two = 20'd330; three = 20'd495; end
    endcase
    case (n)
      2'h1: update_us = one;
      2'h2: update_us = two;
      2'h3: update_us = three;
      default: update_us = one;
    endcase
  endfunction
endpackage

//--- tb/reg_host_model.sv
// host model that drives the register port of the field readout
module reg_host_model (
  // clock
  input  wire logic        sys_clk,
  // register port
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic      [31:0] reg_wdata,
  output logic             reg_rd,
  output logic             burst_start
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 32'h0000_0000;
    reg_rd = 1'b0;
    burst_start = 1'b0;
  end

  // one write; released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // run of reads at rising addresses, optionally led by a snapshot pulse
  task automatic rd(input logic [7:0] a, input int n, input bit snap, input int stall);
    @(posedge sys_clk);
    if (snap) begin
      burst_start <= 1'b1;
      @(posedge sys_clk);
      burst_start <= 1'b0;
      repeat (stall) @(posedge sys_clk);
    end
    reg_addr <= a;
    reg_rd <= 1'b1;
    repeat (n - 1) begin
      @(posedge sys_clk);
      reg_addr <= reg_addr + 8'h01;
    end
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~reg_addr;
  endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the field readout block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import field_readout_pkg::*;

  // design ports
  logic        sys_clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [31:0] reg_wdata;
  logic        reg_rd;
  logic        burst_start;
  logic [31:0] reg_rdata;
  logic [11:0] ax_i, ax_d, ax_s, ay_i, ay_d, ay_s, az_i, at;
  logic        front_end_on;
  logic        fir_enable;
  logic        sample_strobe;
  // bookkeeping
  typedef struct {string what; logic [31:0] val; logic [31:0] mask;} note_type;
  note_type    notes[$];
  note_type    nt;
  int          fails;
  int          checks;
  int          n;
  int          m;
  logic [1:0]  org;
  logic [31:0] last_rd;

  field_readout DUT (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .burst_start(burst_start), .reg_rdata(reg_rdata),
    .adc_x_inner(ax_i), .adc_x_diff(ax_d), .adc_x_sum(ax_s), .adc_y_inner(ay_i), .adc_y_diff(ay_d),
    .adc_y_sum(ay_s), .adc_z_inner(az_i), .adc_temp(at), .front_end_on(front_end_on),
    .fir_enable(fir_enable), .sample_strobe(sample_strobe));
  reg_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .burst_start(burst_start));

  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic note(input string w, input logic [31:0] v, input logic [31:0] k);
    notes.push_back('{w, v, k});
  endtask

  function automatic logic [31:0] cfg(input logic [2:0] bw, input logic [1:0] sc, input logic [2:0] ch);
    return {8'h00, bw, sc, 10'h000, ch, 6'h00};
  endfunction

  // fresh converter values; same makes sums equal differences
  task automatic new_adc(input bit same);
    logic [11:0] xd;
    logic [11:0] yd;
    xd = 12'($urandom);
    yd = 12'($urandom);
    @(posedge sys_clk);
    ax_i <= 12'($urandom);
    ax_d <= xd;
    ax_s <= same ? xd : 12'($urandom);
    ay_i <= 12'($urandom);
    ay_d <= yd;
    ay_s <= same ? yd : 12'($urandom);
    az_i <= 12'($urandom);
  endtask

  // bounded wait for a sample pulse, counting cycles
  task automatic wait_strobe(output int cnt, input int lim);
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
    end while (sample_strobe !== 1'b1 && cnt < lim);
    if (sample_strobe !== 1'b1) begin
      fails++;
      $display("ERROR sample_strobe expected 1 seen %b", sample_strobe);
      report_and_stop();
    end
  endtask

  // settle past the capture edge, note both words, then burst read
  task automatic grab(input logic [1:0] sc, input logic [1:0] o, input logic [31:0] k, input int stall);
    logic [11:0] x;
    logic [11:0] y;
    repeat (3) @(posedge sys_clk);
    x = (sc == SC_INNER) ? ax_i : (sc == SC_DIFF) ? ax_d : ax_s;
    y = (sc == SC_INNER) ? ay_i : (sc == SC_DIFF) ? ay_d : ay_s;
    note("result_upper", {x[11:4], y[11:4], az_i[11:4], 2'b00, at[11:6]}, 32'hffff_ffff);
    note("result_lower", {12'h000, x[3:0], y[3:0], az_i[3:0], o, at[5:0]}, k);
    host.rd(RES_UPPER_ADDR, 2, 1'b1, stall);
  endtask

  // tolerance covers tick rounding plus two percent of the period
  task automatic period(input int exp, input int got);
    check("strobe_period", 32'h1, {31'h0, got > exp - exp / 50 - 10 && got < exp + exp / 50 + 10});
  endtask

  task automatic end_test(input string t);
    $display("test %s done", t);
  endtask

  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // read answers are matched against the oldest note
  always @(posedge sys_clk) begin
    if (reg_rd === 1'b1) begin
      @(negedge sys_clk);
      last_rd = reg_rdata;
      if (notes.size() == 0) begin
        fails++;
        $display("ERROR reg_rdata expected none seen %h", reg_rdata);
      end else begin
        nt = notes.pop_front();
        check(nt.what, nt.val & nt.mask, reg_rdata & nt.mask);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h44d2bf64));
    fails = 0;
    checks = 0;
    resetn = 1'b0;
    {ax_i, ax_d, ax_s, ay_i, ay_d, ay_s, az_i} = '0;
    at = 12'($urandom);
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // reset values, write masks, refused places
    note("sensor_configuration", CONFIG_RESET, '1);
    host.rd(CONFIG_ADDR, 1, 1'b0, 0);
    note("power_control", POWER_RESET, '1);
    host.rd(POWER_ADDR, 1, 1'b0, 0);
    note("unmapped", 32'h0, '1);
    host.rd(8'h55, 1, 1'b0, 0);
    host.wr(CONFIG_ADDR, 32'hffff_ffff);
    host.wr(POWER_ADDR, 32'hffff_ffff);
    host.wr(RES_UPPER_ADDR, 32'hffff_ffff);
    note("result_upper", 32'h0, '1);
    host.rd(RES_UPPER_ADDR, 1, 1'b0, 0);
    note("sensor_configuration", 32'h00ff_ffff, '1);
    host.rd(CONFIG_ADDR, 1, 1'b0, 0);
    note("power_control", 32'h0000_007f, '1);
    host.rd(POWER_ADDR, 1, 1'b0, 0);
    host.wr(POWER_ADDR, 32'h0000_0000);
    for (int b = 0; b < 8; b++) begin
      host.wr(CONFIG_ADDR, cfg(b[2:0], 2'h0, 3'h7));
      @(negedge sys_clk);
      check("fir_enable", {31'h0, b <= 2}, {31'h0, fir_enable});
    end
    host.wr(CONFIG_ADDR, cfg(3'h6, 2'h0, 3'h7));
    new_adc(1'b0);
    end_test("registers");
    // first sample after the startup delay
    wait_strobe(n, 82000);
    check("startup_delay", 32'h1, {31'h0, n > 79000 && n < 81000});
    grab(SC_INNER, 2'h0, '1, 0);
    // new samples land while the burst stalls
    fork
      grab(SC_INNER, 2'h0, '1, 1400);
      begin
        repeat (10) @(posedge sys_clk);
        new_adc(1'b0);
      end
    join
    end_test("burst");
    for (int s = 1; s < 3; s++) begin
      host.wr(CONFIG_ADDR, cfg(3'h6, s[1:0], 3'h7));
      new_adc(1'b0);
      wait_strobe(n, 2000);
      wait_strobe(n, 2000);
      grab(s[1:0], s[1:0], '1, 0);
    end
    // alternating: data fixed, origin must flip between samples
    host.wr(CONFIG_ADDR, cfg(3'h6, SC_ALT, 3'h7));
    new_adc(1'b1);
    wait_strobe(n, 2000);
    for (int i = 0; i < 2; i++) begin
      wait_strobe(n, 2000);
      grab(SC_DIFF, 2'h0, 32'hffff_ff3f, 0);
      repeat (2) @(posedge sys_clk);
      if (i == 1) check("origin_flip", {30'h0, org ^ 2'h3}, {30'h0, last_rd[7:6]});
      org = last_rd[7:6];
    end
    end_test("schemes");
    for (int i = 0; i < 2; i++) begin
      host.wr(CONFIG_ADDR, i == 0 ? cfg(3'h0, 2'h0, 3'h1) : cfg(3'h6, 2'h0, 3'h7));
      wait_strobe(n, 6000);
      wait_strobe(n, 6000);
      wait_strobe(n, 6000);
      period(i == 0 ? 1600 : 630, n);
    end
    end_test("periods");
    // duty cycling with the shortest inactive interval
    host.wr(POWER_ADDR, {25'h0, 3'h0, 2'h0, PS_DUTY});
    wait_strobe(n, 7000);
    wait_strobe(n, 7000);
    repeat (2000) @(negedge sys_clk);
    check("front_end_on", 32'h0, {31'h0, front_end_on});
    wait_strobe(n, 7000);
    period(5630, n + 2000);
    end_test("duty");
    // sleep keeps answering but stops sampling
    host.wr(POWER_ADDR, {30'h0, PS_SLEEP});
    m = 0;
    repeat (1500) begin
      @(negedge sys_clk);
      if (sample_strobe === 1'b1) m++;
    end
    check("sleep_strobes", 32'h0, m);
    check("front_end_on", 32'h0, {31'h0, front_end_on});
    note("power_control", 32'h1, '1);
    host.rd(POWER_ADDR, 1, 1'b0, 0);
    repeat (3) @(posedge sys_clk);
    end_test("sleep");
    // waking starts the full startup delay again, so nothing measures for a while
    host.wr(POWER_ADDR, {30'h0, PS_ACTIVE});
    m = 0;
    repeat (1500) begin
      @(negedge sys_clk);
      if (sample_strobe === 1'b1 || front_end_on === 1'b1) m++;
    end
    check("wake_strobes", 32'h0, m);
    end_test("wake");
    report_and_stop();
  end
endmodule
